// ==== hdl/sibc_defines.svh ====
`ifndef SIBC_DEFINES_SVH
`define SIBC_DEFINES_SVH
// Summary of operation
// - An enabled brown-out detector keeps watching the supply in sleep unless software asked to stop it.
// - The software stop request only acts in the sleep modes that allow it.
// - With the stop request active, the detector turns off as soon as sleep is entered.
// - Any wake-up turns the detector back on with no software help.
// - If the detector was off in sleep, wake-up is stretched to about 60 us before code runs.
// - The sleep-disable bit turns the detector off in eligible modes when one, keeps it on when zero, and resets to zero.
// - The sleep-disable bit only changes through the timed enable sequence; other writes are ignored.
// - Sleep mode code 00 with the sleep instruction enters Idle.
// - Idle gates the core and program memory clocks and leaves all other clocks running.
// - Idle keeps the serial, comparator, converter, start detect, async timer, watchdog and interrupts running.
// - Any enabled external, peripheral or comparator interrupt ends Idle; the noise wake source does not.
// - Entering Idle with the converter enabled starts a conversion.
// - The comparator power-down bit powers the comparator off so it cannot wake Idle.
// - Sleep mode code 01 enters noise reduction, halts io, core and program clocks, and starts a conversion if the converter is enabled.
// - Unused upper bits 7:3 of the sleep control register read as zero.

// ----------------------------------------------------------------
// Codes and timing
// ----------------------------------------------------------------
`define SIBC_SM_IDLE        2'h0
`define SIBC_SM_NOISE       2'h1
`define SIBC_SM_POWER_DOWN  2'h2
`define SIBC_SM_STANDBY     2'h3
`define SIBC_SCR_RESET      8'h00
`define SIBC_SM_LSB         1
`define SIBC_SE_BIT         0
`define SIBC_WINDOW_CYCLES  3'h4
`define SIBC_CLK_NS         20
`define SIBC_WAKE_BOD_NS    60000
`define SIBC_WAKE_BOD_CYC   ((`SIBC_WAKE_BOD_NS + `SIBC_CLK_NS - 1) / `SIBC_CLK_NS)
`define SIBC_WAKE_CYC       1
`endif

// ==== hdl/sibc_pkg.sv ====
package sibc_pkg;
  typedef enum logic [1:0] {
    SIBC_RUN,
    SIBC_SLEEP,
    SIBC_WAKE
  } sibc_state_type;

  // Clock gate enables, one per domain
  typedef struct packed {
    logic core;
    logic program_memory;
    logic peripheral_io;
    logic peripheral;
  } sibc_clk_en_type;

  // Core writes toward the block
  typedef struct packed {
    logic       scr_we;
    logic [7:0] scr_wdata;
    logic       brownout_sleep_disable_we;
    logic       brownout_sleep_disable_wdata;
    logic       brownout_sleep_disable_enable_we;
  } sibc_wr_type;
endpackage

// ==== hdl/sibc_wake_timer.sv ====
`timescale 1ns/1ps
`include "sibc_defines.svh"
module sibc_wake_timer (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Control
  input  wire logic        i_start,
  input  wire logic [11:0] i_cycles,
  // Status
  output logic             o_done
);
  logic [11:0] count_reg;
  logic        busy_reg;
  wire         last_w = busy_reg && (count_reg <= 12'h001);

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_reg <= 12'h000;
      busy_reg  <= 1'b0;
    end else if (i_start) begin
      count_reg <= i_cycles;
      busy_reg  <= 1'b1;
    end else if (busy_reg) begin
      count_reg <= count_reg - 12'h001;
      busy_reg  <= !last_w;
    end
  end

  assign o_done = last_w;
endmodule

// ==== hdl/sibc_sleep_ctrl.sv ====
`timescale 1ns/1ps
`include "sibc_defines.svh"
module sibc_sleep_ctrl (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_resetn,
  // Core side
  input  wire logic                     i_sleep_instr,
  input  wire sibc_pkg::sibc_wr_type    i_wr,
  output logic [7:0]                    o_sleep_control_reg,
  output logic                          o_brownout_sleep_disable,
  output logic                          o_core_stall,
  // Fuses and peripheral controls
  input  wire logic                     i_brownout_level_fuse_en,
  input  wire logic                     i_adc_enable,
  input  wire logic                     i_comparator_power_down,
  // Wake sources, already enabled and synchronous
  input  wire logic                     i_ext_irq,
  input  wire logic                     i_periph_irq,
  input  wire logic                     i_comparator_irq,
  input  wire logic                     i_noise_wake_irq,
  // Outputs to the system
  output sibc_pkg::sibc_clk_en_type     o_clk_en,
  output logic                          o_brownout_detector_en,
  output logic                          o_comparator_power,
  output logic                          o_adc_start,
  output logic [1:0]                    o_sleep_mode
);
  import sibc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  sibc_state_type state_reg;
  sibc_state_type state_next;
  logic [2:0]     scr_reg;
  logic           brownout_sleep_disable_reg;
  logic [2:0]     window_reg;
  logic           bod_off_reg;
  logic           adc_start_reg;
  logic [1:0]     mode_reg;
  logic           timer_done;

  function automatic logic brownout_sleep_disable_allowed(input logic [1:0] mode);
    brownout_sleep_disable_allowed = (mode == `SIBC_SM_POWER_DOWN) || (mode == `SIBC_SM_STANDBY);
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire [1:0] sm_sel_w     = scr_reg[`SIBC_SM_LSB +: 2];
  wire       sleep_en_w   = scr_reg[`SIBC_SE_BIT];
  wire       enter_w      = (state_reg == SIBC_RUN) && i_sleep_instr && sleep_en_w;
  wire       window_open_w = (window_reg != 3'h0);
  wire       comp_wake_w  = i_comparator_irq && !i_comparator_power_down;
  wire       idle_wake_w  = i_ext_irq || i_periph_irq || comp_wake_w;
  wire       noise_wake_w = i_ext_irq || i_noise_wake_irq;
  wire       deep_wake_w  = i_ext_irq;
  wire       wake_w       = (mode_reg == `SIBC_SM_IDLE)  ? idle_wake_w :
                            (mode_reg == `SIBC_SM_NOISE) ? noise_wake_w : deep_wake_w;
  wire       sleeping_w   = (state_reg == SIBC_SLEEP);
  wire       turn_off_w   = enter_w && brownout_sleep_disable_reg && brownout_sleep_disable_allowed(sm_sel_w);
  wire       adc_go_w     = enter_w && i_adc_enable &&
                            ((sm_sel_w == `SIBC_SM_IDLE) || (sm_sel_w == `SIBC_SM_NOISE));
  wire [11:0] wake_cyc_w  = bod_off_reg ? 12'(`SIBC_WAKE_BOD_CYC)
                                        : 12'(`SIBC_WAKE_CYC);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SIBC_RUN:   if (enter_w) state_next = SIBC_SLEEP;
      SIBC_SLEEP: if (wake_w) state_next = SIBC_WAKE;
      SIBC_WAKE:  if (timer_done) state_next = SIBC_RUN;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= SIBC_RUN;
      scr_reg   <= 3'(`SIBC_SCR_RESET);
      mode_reg  <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (i_wr.scr_we) begin
        scr_reg <= i_wr.scr_wdata[2:0];
      end
      if (enter_w) begin
        mode_reg <= sm_sel_w;
      end
    end
  end

  // Protected write: enable opens the window, expiry shuts it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      brownout_sleep_disable_reg   <= 1'b0;
      window_reg <= 3'h0;
    end else begin
      if (i_wr.brownout_sleep_disable_enable_we) begin
        window_reg <= `SIBC_WINDOW_CYCLES;
      end else if (window_open_w) begin
        window_reg <= window_reg - 3'h1;
      end
      if (i_wr.brownout_sleep_disable_we && window_open_w && !i_wr.brownout_sleep_disable_enable_we) begin
        brownout_sleep_disable_reg <= i_wr.brownout_sleep_disable_wdata;
      end
    end
  end

  // Detector is off only from sleep entry to wake; wake always restores it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      bod_off_reg   <= 1'b0;
      adc_start_reg <= 1'b0;
    end else begin
      if (turn_off_w) begin
        bod_off_reg <= 1'b1;
      end else if (state_reg == SIBC_WAKE && timer_done) begin
        bod_off_reg <= 1'b0;
      end
      adc_start_reg <= adc_go_w;
    end
  end

  sibc_wake_timer u_wake_timer (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_start  (sleeping_w && wake_w),
    .i_cycles (wake_cyc_w),
    .o_done   (timer_done)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Detector stays on during the wake delay so it settles before code runs
  assign o_brownout_detector_en = i_brownout_level_fuse_en &&
                                  !(sleeping_w && bod_off_reg);
  assign o_sleep_control_reg     = {5'h00, scr_reg};
  assign o_brownout_sleep_disable = brownout_sleep_disable_reg;
  assign o_core_stall            = (state_reg != SIBC_RUN);
  assign o_clk_en.core           = !sleeping_w;
  assign o_clk_en.program_memory = !sleeping_w;
  assign o_clk_en.peripheral_io  = !(sleeping_w && mode_reg != `SIBC_SM_IDLE);
  assign o_clk_en.peripheral     = !sleeping_w || (mode_reg == `SIBC_SM_IDLE)
                                   || (mode_reg == `SIBC_SM_NOISE);
  assign o_comparator_power      = !i_comparator_power_down;
  assign o_adc_start             = adc_start_reg;
  assign o_sleep_mode            = mode_reg;
endmodule

// ==== sim/sibc_props.sv ====
`timescale 1ns/1ps
`include "sibc_defines.svh"
module sibc_props (
  // Watched ports
  input wire logic                      i_clk,
  input wire logic                      i_resetn,
  input wire sibc_pkg::sibc_wr_type     i_wr,
  input wire logic                      i_brownout_level_fuse_en,
  input wire logic                      i_adc_enable,
  input wire logic                      i_comparator_power_down,
  input wire logic                      i_ext_irq,
  input wire logic [7:0]                o_sleep_control_reg,
  input wire logic                      o_brownout_sleep_disable,
  input wire logic                      o_core_stall,
  input wire sibc_pkg::sibc_clk_en_type o_clk_en,
  input wire logic                      o_brownout_detector_en,
  input wire logic                      o_comparator_power,
  input wire logic                      o_adc_start,
  input wire logic [1:0]                o_sleep_mode
);
  import sibc_pkg::*;
  // Sleeping proper, not the wake stretch
  wire logic asleep = o_core_stall && !o_clk_en.core;
  wire logic det_off = asleep && o_sleep_mode[1] && o_brownout_sleep_disable;
  // Edges since the last enable write, saturating so old enables never reopen
  logic [3:0] since_en;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      since_en <= 4'h0;
    end else if (i_wr.brownout_sleep_disable_enable_we) begin
      since_en <= 4'h1;
    end else if (since_en != 4'h0 && since_en != 4'hf) begin
      since_en <= since_en + 4'h1;
    end
  end
  wire logic in_window = (since_en != 4'h0) && (since_en <= {1'b0, `SIBC_WINDOW_CYCLES});
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ----
  // Checks
  // ----
  AST_UPPER_ZERO: assert property (o_sleep_control_reg[7:3] == 5'h00)
    else $error("upper control bits not zero");
  AST_CMP_POWER: assert property (o_comparator_power == !i_comparator_power_down)
    else $error("comparator power wrong");
  AST_BROWNOUT_SLEEP_DISABLE_HOLD: assert property (!i_wr.brownout_sleep_disable_we |=> $stable(o_brownout_sleep_disable))
    else $error("disable bit moved without write");
  AST_BROWNOUT_SLEEP_DISABLE_WINDOW: assert property ((!in_window || i_wr.brownout_sleep_disable_enable_we) |=> $stable(o_brownout_sleep_disable))
    else $error("disable bit moved outside window");
  AST_DET_OFF: assert property (det_off |-> !o_brownout_detector_en)
    else $error("detector on in eligible sleep");
  AST_DET_KEEP: assert property (i_brownout_level_fuse_en && !det_off |-> o_brownout_detector_en)
    else $error("detector off outside eligible sleep");
  AST_IDLE_CLK: assert property (asleep && o_sleep_mode == 2'h0 |-> o_clk_en == 4'h3)
    else $error("idle clock gates wrong");
  AST_NOISE_CLK: assert property (asleep && o_sleep_mode == 2'h1 |-> o_clk_en == 4'h1)
    else $error("noise clock gates wrong");
  AST_ADC_START: assert property ($rose(asleep) && !o_sleep_mode[1] && i_adc_enable |-> ##[0:1] o_adc_start)
    else $error("no conversion start on entry");
  AST_WAKE_STRETCH: assert property ($rose(o_brownout_detector_en) && o_core_stall |-> o_core_stall[*8])
    else $error("wake not stretched");
  AST_EXT_WAKE: assert property (asleep && i_ext_irq |-> ##[1:2] !asleep)
    else $error("no wake on interrupt");
endmodule
bind sibc_sleep_ctrl sibc_props u_sibc_props (.*);

// ==== sim/sibc_wake_model.sv ====
`timescale 1ns/1ps
module sibc_wake_model (
  // Clock and core state
  input  wire logic       i_clk,
  input  wire logic       i_core_stall,
  input  wire logic [1:0] i_wake_sel,
  // Wake sources, held until the core runs
  output logic            o_ext_irq,
  output logic            o_periph_irq,
  output logic            o_comparator_irq
);
  logic [3:0] wait_reg = 4'h0;
  always_ff @(posedge i_clk)
    wait_reg <= !i_core_stall ? 4'h0 : (wait_reg == 4'hf) ? wait_reg : wait_reg + 4'h1;
  wire logic act = wait_reg > 4'h3;
  assign o_ext_irq        = act && i_wake_sel == 2'h0;
  assign o_periph_irq     = act && i_wake_sel == 2'h1;
  assign o_comparator_irq = act && i_wake_sel == 2'h2;
endmodule

// ==== sim/sibc_sleep_ctrl_tb.sv ====
`timescale 1ns/1ps
module sibc_sleep_ctrl_tb;
  import sibc_pkg::*;
  logic i_clk = 0, i_resetn = 0, i_sleep_instr = 0, i_adc_enable = 1;
  logic i_comparator_power_down = 0, i_brownout_level_fuse_en = 1, i_noise_wake_irq = 0;
  logic i_ext_irq, i_periph_irq, i_comparator_irq, o_brownout_sleep_disable, o_core_stall;
  logic o_brownout_detector_en, o_comparator_power, o_adc_start;
  logic [1:0] o_sleep_mode, wake_sel = 2'h3;
  logic [7:0] o_sleep_control_reg;
  sibc_wr_type i_wr = '0;
  sibc_clk_en_type o_clk_en;
  int errors = 0, check_count = 0, adc_pulses = 0, n;
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) if (o_adc_start === 1'b1) adc_pulses <= adc_pulses + 1;
  sibc_sleep_ctrl u_sibc_sleep_ctrl (
    .i_clk                    (i_clk),
    .i_resetn                 (i_resetn),
    .i_sleep_instr            (i_sleep_instr),
    .i_wr                     (i_wr),
    .o_sleep_control_reg      (o_sleep_control_reg),
    .o_brownout_sleep_disable (o_brownout_sleep_disable),
    .o_core_stall             (o_core_stall),
    .i_brownout_level_fuse_en (i_brownout_level_fuse_en),
    .i_adc_enable             (i_adc_enable),
    .i_comparator_power_down  (i_comparator_power_down),
    .i_ext_irq                (i_ext_irq),
    .i_periph_irq             (i_periph_irq),
    .i_comparator_irq         (i_comparator_irq),
    .i_noise_wake_irq         (i_noise_wake_irq),
    .o_clk_en                 (o_clk_en),
    .o_brownout_detector_en   (o_brownout_detector_en),
    .o_comparator_power       (o_comparator_power),
    .o_adc_start              (o_adc_start),
    .o_sleep_mode             (o_sleep_mode)
  );
  sibc_wake_model u_sibc_wake_model (.i_clk(i_clk), .i_core_stall(o_core_stall),
    .i_wake_sel(wake_sel), .o_ext_irq(i_ext_irq), .o_periph_irq(i_periph_irq),
    .o_comparator_irq(i_comparator_irq));
  // ----
  // Tasks
  // ----
  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task scr(input logic [7:0] d);
    @(posedge i_clk) i_wr.scr_we <= 1'b1;
    i_wr.scr_wdata <= d;
    @(posedge i_clk) i_wr.scr_we <= 1'b0;
    // Let the register update land before any readback
    #1;
  endtask
  // Gap 0 skips the enable, so the write falls outside any window and is ignored
  task brownout_sleep_disable(input int gap, input logic v);
    if (gap > 0) begin
      @(posedge i_clk) i_wr.brownout_sleep_disable_enable_we <= 1'b1;
      @(posedge i_clk) i_wr.brownout_sleep_disable_enable_we <= 1'b0;
      repeat (gap - 1) @(posedge i_clk);
    end
    @(posedge i_clk) i_wr.brownout_sleep_disable_we <= 1'b1;
    i_wr.brownout_sleep_disable_wdata <= v;
    @(posedge i_clk) i_wr.brownout_sleep_disable_we <= 1'b0;
    #1;
  endtask
  task wait_stall(input logic lvl);
    n = 0;
    while (o_core_stall !== lvl && n < 4000) begin
      @(posedge i_clk);
      #1 n++;
    end
    check("stall", o_core_stall, lvl);
  endtask
  // Sleep, stay asleep without a source, then wake from source sel
  task nap(input logic [1:0] m, input logic [3:0] ck, input logic det, input logic [1:0] sel);
    scr({5'h00, m, 1'b1});
    @(posedge i_clk) i_sleep_instr <= 1'b1;
    @(posedge i_clk) i_sleep_instr <= 1'b0;
    wait_stall(1'b1);
    if (!m[1]) check("clk_en", o_clk_en, ck);
    check("det_en", o_brownout_detector_en, det);
    check("mode", o_sleep_mode, m);
    repeat (8) @(posedge i_clk);
    #1 check("held", o_core_stall, 1'b1);
    @(posedge i_clk) wake_sel <= sel;
    wait_stall(1'b0);
    @(posedge i_clk) wake_sel <= 2'h3;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    #(20 * 20000);
    errors++;
    final_report;
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_resetn <= 1'b1;
    check("scr", o_sleep_control_reg, 8'h00);
    check("brownout_sleep_disable", o_brownout_sleep_disable, 1'b0);
    check("clk_en", o_clk_en, 4'hf);
    scr(8'hfa);
    check("scr", o_sleep_control_reg, 8'h02);
    brownout_sleep_disable(0, 1'b1);
    check("brownout_sleep_disable", o_brownout_sleep_disable, 1'b0);
    brownout_sleep_disable(6, 1'b1);
    check("brownout_sleep_disable", o_brownout_sleep_disable, 1'b0);
    brownout_sleep_disable(1, 1'b1);
    check("brownout_sleep_disable", o_brownout_sleep_disable, 1'b1);
    nap(2'h0, 4'h3, 1'b1, 2'h1);
    check("fast", n < 20, 1'b1);
    check("adc", adc_pulses, 8'h01);
    nap(2'h1, 4'h1, 1'b1, 2'h0);
    check("adc", adc_pulses, 8'h02);
    @(posedge i_clk) i_comparator_power_down <= 1'b1;
    wake_sel <= 2'h2;
    @(posedge i_clk) check("cmp", o_comparator_power, 1'b0);
    nap(2'h0, 4'h3, 1'b1, 2'h0);
    nap(2'h2, 4'h0, 1'b0, 2'h0);
    check("stretch", n > 2995 && n < 3015, 1'b1);
    check("det_en", o_brownout_detector_en, 1'b1);
    final_report;
  end
endmodule
